// ### core/sea_buf.sv
`timescale 1ns/10ps
`default_nettype none

module sea_buf #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic flush,
	sea_strm_if.cons  wr,
	sea_strm_if.prod  rd
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] ent;
		logic [AW-1:0]           wi;
		logic [AW-1:0]           ri;
		logic [CW-1:0]           cnt;
	} sea_buf_t;

	sea_buf_t b_r;
	sea_buf_t b_nxt;
	logic     push;
	logic     pop;

	assign push = wr.valid && wr.ready;
	assign pop  = rd.valid && rd.ready;

	// Ring of DEPTH entries; flush drops stale words between reads
	always_comb begin
		b_nxt = b_r;
		if (push) begin
			b_nxt.ent[b_r.wi] = wr.data;
			b_nxt.wi = (b_r.wi == AW'(DEPTH - 1)) ? '0 : AW'(b_r.wi + 1'b1);
		end
		if (pop) begin
			b_nxt.ri = (b_r.ri == AW'(DEPTH - 1)) ? '0 : AW'(b_r.ri + 1'b1);
		end
		b_nxt.cnt = CW'(b_r.cnt + CW'(push) - CW'(pop));
		if (flush || rst) begin
			b_nxt.wi  = '0;
			b_nxt.ri  = '0;
			b_nxt.cnt = '0;
		end
		if (rst) begin
			b_nxt.ent = '0;
		end
	end

	always_ff @(posedge clk) begin
		b_r <= b_nxt;
	end

	// Full stalls the filler, empty holds the drain
	assign wr.ready = (b_r.cnt != CW'(DEPTH));
	assign rd.valid = (b_r.cnt != '0);
	assign rd.data  = b_r.ent[b_r.ri];

endmodule: sea_buf

`default_nettype wire

// ### core/sea_eeprom.sv
// Summary of operation
// - Storage is 32 bytes or 16 words.
// - Decodes read, write, erase, erase-all, write-all.
// - Read loads pointer, shifts that location out.
// - Pointer advances; stream continues while selected.
// - Pointer wraps to zero past top location.
// - Programming is self-timed, serial clock irrelevant.
// - Write overwrites location, no prior erase needed.
// - One write programs one whole location.
// - Busy/ready shown on output while selected.
// - First clock ignored, then wait start bit.
// - Four opcode bits, then four/five address bits.
// - Dummy zero first, MSB first, none between.
// - Starts write-disabled; enable/disable commands gate programming.
`timescale 1ns/10ps
`default_nettype none

module sea_eeprom
	import sea_pkg::*;
#(
	parameter int PROG_CYC = PROG_CYC_DEF
) (
	input  wire logic CLK,
	input  wire logic SYS_RST,
	input  wire logic SEL,
	input  wire logic SCK,
	input  wire logic SDI,
	input  wire logic ORG_SEL,
	output logic      SDO,
	output logic      SDO_OE_N
);

	localparam int BCW = $clog2(PROG_CYC + 1);

	typedef struct packed {
		sea_state_t              state;
		sea_op_t                 op;
		logic                    en;
		logic                    org;
		logic [4:0]              bits;
		logic [3:0]              opc;
		logic [4:0]              addr;
		logic [15:0]             dat;
		logic [4:0]              ptr;
		logic [15:0]             sh;
		logic [4:0]              sh_cnt;
		logic                    q;
		logic                    q_oe_n;
		logic [BCW-1:0]          busy_cnt;
		logic [NWORDS-1:0][15:0] mem;
	} sea_core_t;

	sea_core_t st_r;
	sea_core_t st_nxt;

	logic [IN_N-1:0] pin_lvl;
	logic [IN_N-1:0] pin_rise;
	logic [IN_N-1:0] pin_fall;
	logic            cs;
	logic            cs_rise;
	logic            cs_fall;
	logic            sck_rise;
	logic            sdi;
	logic            org_pin;
	logic            pop;

	sea_strm_if #(.W(WORD_W)) fill ();
	sea_strm_if #(.W(WORD_W)) drain ();

	// Location read; byte 2n is the high half of word n
	function automatic logic [15:0] loc_rd(
		input logic [NWORDS-1:0][15:0] m,
		input logic [4:0]              a,
		input logic                    o
	);
		logic [15:0] w;
		w = o ? m[a[3:0]] : m[a[4:1]];
		loc_rd = o ? w : {8'h00, (a[0] ? w[7:0] : w[15:8])};
	endfunction: loc_rd

	// Whole-location program, the old value simply overwritten
	function automatic logic [NWORDS-1:0][15:0] loc_wr(
		input logic [NWORDS-1:0][15:0] m,
		input logic [4:0]              a,
		input logic                    o,
		input logic [15:0]             d
	);
		loc_wr = m;
		if (o) begin
			loc_wr[a[3:0]] = d;
		end else if (a[0]) begin
			loc_wr[a[4:1]][7:0] = d[7:0];
		end else begin
			loc_wr[a[4:1]][15:8] = d[7:0];
		end
	endfunction: loc_wr

	// Location width and address length by organisation
	function automatic logic [4:0] loc_bits(input logic o);
		loc_bits = o ? WORD_BITS : BYTE_BITS;
	endfunction: loc_bits

	function automatic logic [4:0] addr_bits(input logic o);
		addr_bits = o ? WORD_ABITS : BYTE_ABITS;
	endfunction: addr_bits

	// Pins come from the host's domain, so all pass the synchroniser
	sea_sync #(
		.W (IN_N)
	) u_sync (
		.clk  (CLK),
		.rst  (SYS_RST),
		.din  ({ORG_SEL, SDI, SCK, SEL}),
		.lvl  (pin_lvl),
		.rise (pin_rise),
		.fall (pin_fall)
	);

	assign cs       = pin_lvl[IN_SEL];
	assign cs_rise  = pin_rise[IN_SEL];
	assign cs_fall  = pin_fall[IN_SEL];
	assign sck_rise = pin_rise[IN_SCK];
	assign sdi      = pin_lvl[IN_SDI];
	assign org_pin  = pin_lvl[IN_ORG];

	// Prefetch of read words; a stalled serial clock just leaves it full
	sea_buf #(
		.W     (WORD_W),
		.DEPTH (2)
	) u_buf (
		.clk   (CLK),
		.rst   (SYS_RST),
		.flush (st_r.state != ST_READ),
		.wr    (fill),
		.rd    (drain)
	);

	assign fill.valid  = (st_r.state == ST_READ);
	assign fill.data   = loc_rd(st_r.mem, st_r.ptr, st_r.org);
	assign drain.ready = pop;

	// Command sequencer, output shifter and programming timer
	always_comb begin
		logic [4:0]  a;
		logic [15:0] ld;
		st_nxt = st_r;
		pop    = 1'b0;
		a      = {st_r.addr[3:0], sdi};
		ld     = st_r.org ? drain.data : {drain.data[7:0], 8'h00};

		// Pointer advances on each word taken into the buffer
		if (fill.valid && fill.ready) begin
			if (st_r.org) begin
				st_nxt.ptr = {1'b0, 4'(st_r.ptr[3:0] + 4'h1)};
			end else begin
				st_nxt.ptr = 5'(st_r.ptr + 5'h01);
			end
		end

		unique case (st_r.state)
			ST_IDLE: begin
				st_nxt.q_oe_n = 1'b1;
				if (cs_rise) begin
					st_nxt.state = ST_FIRST;
				end
			end
			ST_FIRST: begin
				if (sck_rise) begin
					st_nxt.state = ST_START;
				end
			end
			ST_START: begin
				if (sck_rise && sdi) begin
					st_nxt.state = ST_OPC;
					st_nxt.bits  = '0;
					st_nxt.org   = org_pin;
				end
			end
			ST_OPC: begin
				if (sck_rise) begin
					st_nxt.opc  = {st_r.opc[2:0], sdi};
					st_nxt.bits = 5'(st_r.bits + 5'h01);
					if (st_r.bits == 5'(OPC_BITS - 5'h01)) begin
						st_nxt.state = ST_ADDR;
						st_nxt.bits  = '0;
						st_nxt.addr  = '0;
					end
				end
			end
			ST_ADDR: begin
				if (sck_rise) begin
					st_nxt.addr = a;
					st_nxt.bits = 5'(st_r.bits + 5'h01);
					if (st_r.bits == 5'(addr_bits(st_r.org) - 5'h01)) begin
						st_nxt.bits  = '0;
						st_nxt.state = ST_WAIT;
						// Instruction decode on the last address bit
						unique case (st_r.opc[3:2])
							OPC_READ: begin
								st_nxt.state  = ST_READ;
								st_nxt.ptr    = a;
								st_nxt.q      = 1'b0;
								st_nxt.q_oe_n = 1'b0;
								st_nxt.sh_cnt = '0;
							end
							OPC_WRITE: begin
								st_nxt.op = OP_WRITE;
								if (st_r.en) begin
									st_nxt.state = ST_DATA;
								end
							end
							OPC_ERASE: begin
								st_nxt.op = OP_ERASE;
								if (st_r.en) begin
									st_nxt.state = ST_ARM;
								end
							end
							OPC_EXT: begin
								unique case (st_r.opc[1:0])
									EXT_EN:  st_nxt.en = 1'b1;
									EXT_DIS: st_nxt.en = 1'b0;
									EXT_WRAL: begin
										st_nxt.op = OP_WRAL;
										if (st_r.en) begin
											st_nxt.state = ST_DATA;
										end
									end
									EXT_ERAL: begin
										st_nxt.op = OP_ERAL;
										if (st_r.en) begin
											st_nxt.state = ST_ARM;
										end
									end
								endcase
							end
						endcase
					end
				end
			end
			ST_READ: begin
				// Reload from the buffer with no dummy bit in between
				if (sck_rise) begin
					if (st_r.sh_cnt == '0) begin
						pop = drain.valid;
						if (drain.valid) begin
							st_nxt.q      = ld[15];
							st_nxt.sh     = {ld[14:0], 1'b0};
							st_nxt.sh_cnt = 5'(loc_bits(st_r.org) - 5'h01);
						end
					end else begin
						st_nxt.q      = st_r.sh[15];
						st_nxt.sh     = {st_r.sh[14:0], 1'b0};
						st_nxt.sh_cnt = 5'(st_r.sh_cnt - 5'h01);
					end
				end
			end
			ST_DATA: begin
				if (sck_rise) begin
					st_nxt.dat  = {st_r.dat[14:0], sdi};
					st_nxt.bits = 5'(st_r.bits + 5'h01);
					if (st_r.bits == 5'(loc_bits(st_r.org) - 5'h01)) begin
						st_nxt.state = ST_ARM;
					end
				end
			end
			ST_ARM: begin
				// Deselect launches the cycle; surplus clocks are ignored
				if (cs_fall) begin
					st_nxt.state    = ST_BUSY;
					st_nxt.busy_cnt = BCW'(PROG_CYC - 1);
				end
			end
			ST_WAIT: begin
				st_nxt.q_oe_n = 1'b1;
			end
			ST_BUSY: begin
				// Counts on CLK only, so SCK may stop or run
				st_nxt.q      = 1'b0;
				st_nxt.q_oe_n = ~cs;
				if (st_r.busy_cnt == '0) begin
					st_nxt.state = ST_DONE;
					unique case (st_r.op)
						OP_WRITE: begin
							st_nxt.mem = loc_wr(st_r.mem, st_r.addr,
								st_r.org, st_r.dat);
						end
						OP_ERASE: begin
							st_nxt.mem = loc_wr(st_r.mem, st_r.addr,
								st_r.org, ERASED);
						end
						OP_WRAL: begin
							for (int i = 0; i < NWORDS; i++) begin
								st_nxt.mem[i] = st_r.org ? st_r.dat
									: {st_r.dat[7:0], st_r.dat[7:0]};
							end
						end
						OP_ERAL: begin
							st_nxt.mem = '1;
						end
						default: begin
							st_nxt.mem = st_r.mem;
						end
					endcase
				end else begin
					st_nxt.busy_cnt = BCW'(st_r.busy_cnt - 1'b1);
				end
			end
			ST_DONE: begin
				st_nxt.q      = 1'b1;
				st_nxt.q_oe_n = ~cs;
			end
			default: begin
				st_nxt.state = ST_IDLE;
			end
		endcase

		// Deselect aborts any instruction not yet armed or programming
		if (cs_fall && st_r.state != ST_ARM && st_r.state != ST_BUSY) begin
			st_nxt.state  = ST_IDLE;
			st_nxt.q_oe_n = 1'b1;
		end

		// Reset leaves the array erased and programming disabled
		if (SYS_RST) begin
			st_nxt        = '0;
			st_nxt.q_oe_n = 1'b1;
			st_nxt.mem    = '1;
			st_nxt.en     = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		st_r <= st_nxt;
	end

	// Pin outputs straight from state flops
	assign SDO      = st_r.q;
	assign SDO_OE_N = st_r.q_oe_n;

endmodule: sea_eeprom

`default_nettype wire

// ### core/sea_pkg.sv
package sea_pkg;

	// Storage geometry
	localparam int          NWORDS     = 16;
	localparam int          WORD_W     = 16;
	localparam logic [4:0]  WORD_BITS  = 5'h10;
	localparam logic [4:0]  BYTE_BITS  = 5'h08;
	localparam logic [4:0]  WORD_ABITS = 5'h04;
	localparam logic [4:0]  BYTE_ABITS = 5'h05;
	localparam logic [4:0]  OPC_BITS   = 5'h04;
	localparam logic [15:0] ERASED     = 16'hffff;

	// Opcode classes (upper two bits) and extended codes (lower two)
	localparam logic [1:0] OPC_EXT   = 2'h0;
	localparam logic [1:0] OPC_WRITE = 2'h1;
	localparam logic [1:0] OPC_READ  = 2'h2;
	localparam logic [1:0] OPC_ERASE = 2'h3;
	localparam logic [1:0] EXT_DIS   = 2'h0;
	localparam logic [1:0] EXT_WRAL  = 2'h1;
	localparam logic [1:0] EXT_ERAL  = 2'h2;
	localparam logic [1:0] EXT_EN    = 2'h3;

	// Bit positions of the pin vector fed through the synchroniser
	localparam int IN_SEL = 0;
	localparam int IN_SCK = 1;
	localparam int IN_SDI = 2;
	localparam int IN_ORG = 3;
	localparam int IN_N   = 4;

	// Programming time, longest figure, rounded down to clock cycles
	localparam int PROG_TIME_MS = 10;
	localparam int CLK_FREQ_KHZ = 100000;
	localparam int PROG_CYC_DEF = PROG_TIME_MS * CLK_FREQ_KHZ;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_FIRST = 4'h1,
		ST_START = 4'h2,
		ST_OPC   = 4'h3,
		ST_ADDR  = 4'h4,
		ST_READ  = 4'h5,
		ST_DATA  = 4'h6,
		ST_ARM   = 4'h7,
		ST_WAIT  = 4'h8,
		ST_BUSY  = 4'h9,
		ST_DONE  = 4'ha
	} sea_state_t;

	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_WRITE = 3'h1,
		OP_ERASE = 3'h2,
		OP_WRAL  = 3'h3,
		OP_ERAL  = 3'h4
	} sea_op_t;

endpackage: sea_pkg

// ### core/sea_strm_if.sv
`timescale 1ns/10ps
`default_nettype none

// Word stream with valid/ready handshake
interface sea_strm_if #(parameter int W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport prod (output valid, output data, input ready);
	modport cons (input valid, input data, output ready);
endinterface: sea_strm_if

`default_nettype wire

// ### core/sea_sync.sv
`timescale 1ns/10ps
`default_nettype none

module sea_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sea_sync_t;

	sea_sync_t r_r;
	sea_sync_t r_nxt;

	// Two-stage capture; edges come from stage two against stage three
	always_comb begin
		r_nxt.s1 = din;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		if (rst) begin
			r_nxt = '0;
		end
	end

	always_ff @(posedge clk) begin
		r_r <= r_nxt;
	end

	// First stage is never looked at here, only by stage two
	assign lvl  = r_r.s2;
	assign rise = r_r.s2 & ~r_r.s3;
	assign fall = ~r_r.s2 & r_r.s3;

endmodule: sea_sync

`default_nettype wire

// ### testbench/sea_eeprom_bench.sv
`timescale 1ns/10ps
`default_nettype none

module sea_eeprom_bench
	import sea_pkg::*;
;
	localparam int PROG_N = 50;
	logic clk       = 1'b0;
	logic sys_rst   = 1'b1;
	logic org_sel   = 1'b1;
	logic sel;
	logic sck;
	logic sdi;
	logic sdo;
	logic sdo_oe_n;
	int   error_cnt = 0;
	int   checks    = 0;

	// Short programming time keeps the run brief
	sea_eeprom #(.PROG_CYC(PROG_N)) i_dut (
		.CLK     (clk),
		.SYS_RST (sys_rst),
		.SEL     (sel),
		.SCK     (sck),
		.SDI     (sdi),
		.ORG_SEL (org_sel),
		.SDO     (sdo),
		.SDO_OE_N(sdo_oe_n)
	);

	sea_host i_host (
		.clk     (clk),
		.sel     (sel),
		.sck     (sck),
		.sdi     (sdi),
		.sdo     (sdo),
		.sdo_oe_n(sdo_oe_n)
	);

	always #5 clk = ~clk;

	task automatic report_and_stop();
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask: report_and_stop

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask: check

	// Instruction frame; data field only for write codes
	task automatic op(input logic [3:0] c, input logic [4:0] a,
		input logic [15:0] d);
		logic        dum;
		logic [15:0] q;
		i_host.cmd(c, a, org_sel ? 4 : 5, 1'b0, dum);
		if (c[3:2] == OPC_WRITE || c == {OPC_EXT, EXT_WRAL})
			i_host.shift(d, org_sel ? 16 : 8, q);
		i_host.stop();
	endtask: op

	// Busy first, then ready under a bounded wait
	task automatic prog(input logic run);
		logic busy;
		logic rdy;
		int   n;
		i_host.poll(run, busy, rdy, n);
		check({15'h0, busy}, 16'h1);
		check({15'h0, rdy}, 16'h1);
		if (n >= 3000) begin
			error_cnt++;
			$display("mismatch at %0t: no ready", $time);
			report_and_stop();
		end
	endtask: prog

	// Sequential read of n locations, first expected in the top slice
	task automatic rd(input logic [4:0] a, input int n,
		input logic [47:0] e);
		logic        dum;
		logic [15:0] q;
		i_host.cmd({OPC_READ, 2'h0}, a, org_sel ? 4 : 5, 1'b0, dum);
		check({15'h0, dum}, 16'h0);
		for (int i = 0; i < n; i++) begin
			i_host.shift(16'h0, org_sel ? 16 : 8, q);
			check(q, e[47-16*i -: 16]);
		end
		i_host.stop();
	endtask: rd

	// Write before enable is ignored
	task automatic s_protect();
		op({OPC_WRITE, 2'h0}, 5'h02, 16'h1234);
		rd(5'h02, 1, 48'hffff00000000);
	endtask: s_protect

	// Overwrite without erase, then read across the top
	task automatic s_word();
		op({OPC_EXT, EXT_EN}, 5'h00, 16'h0);
		op({OPC_WRITE, 2'h0}, 5'h0f, 16'ha5c3);
		prog(1'b1);
		op({OPC_WRITE, 2'h0}, 5'h0f, 16'h5a3c);
		prog(1'b0);
		op({OPC_WRITE, 2'h0}, 5'h00, 16'h1234);
		prog(1'b0);
		rd(5'h0f, 3, 48'h5a3c1234ffff);
	endtask: s_word

	// A one on the first pulse must not be taken as the start bit
	task automatic s_first();
		logic        dum;
		logic [15:0] q;
		i_host.cmd({OPC_READ, 2'h0}, 5'h0f, 4, 1'b1, dum);
		check({15'h0, dum}, 16'h0);
		i_host.shift(16'h0, 16, q);
		check(q, 16'h5a3c);
		i_host.stop();
	endtask: s_first

	// One byte programmed, its neighbour kept, wrap 31 to 0
	task automatic s_byte();
		org_sel = 1'b0;
		op({OPC_WRITE, 2'h0}, 5'h1f, 16'h0081);
		prog(1'b0);
		rd(5'h1e, 3, 48'h005a00810012);
		org_sel = 1'b1;
	endtask: s_byte

	// Erase, fill, clear all, then disable
	task automatic s_codes();
		op({OPC_ERASE, 2'h0}, 5'h00, 16'h0);
		prog(1'b0);
		rd(5'h0f, 2, 48'h5a81ffff0000);
		op({OPC_EXT, EXT_WRAL}, 5'h00, 16'h0f0f);
		prog(1'b0);
		rd(5'h07, 2, 48'h0f0f0f0f0000);
		op({OPC_EXT, EXT_ERAL}, 5'h00, 16'h0);
		prog(1'b0);
		rd(5'h03, 1, 48'hffff00000000);
		op({OPC_EXT, EXT_DIS}, 5'h00, 16'h0);
		op({OPC_WRITE, 2'h0}, 5'h03, 16'h0);
		rd(5'h03, 1, 48'hffff00000000);
	endtask: s_codes

	initial begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (6) @(negedge clk);
		s_protect();
		s_word();
		s_first();
		s_byte();
		s_codes();
		report_and_stop();
	end
endmodule: sea_eeprom_bench

`default_nettype wire

// ### testbench/sea_eeprom_chk.sv
`timescale 1ns/10ps
`default_nettype none

// Port watch on the serial output and its enable
module sea_eeprom_chk #(
	parameter int PROG_CYC = 50
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic SEL,
	input wire logic SCK,
	input wire logic SDO,
	input wire logic SDO_OE_N
);
	logic        sck_d_r;
	logic [7:0]  age_r;
	logic [7:0]  lo_r;
	logic [31:0] busy_r;

	// Ages since clock rise and deselect; busy run without clocking
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sck_d_r <= 1'b0;
			age_r   <= 8'hff;
			lo_r    <= 8'h00;
			busy_r  <= 32'h0;
		end else begin
			sck_d_r <= SCK;
			age_r   <= (SCK && !sck_d_r) ? 8'h00 : age_r + {7'h00, ~&age_r};
			lo_r    <= SEL ? 8'h00 : lo_r + {7'h00, ~&lo_r};
			busy_r  <= (SEL && !SDO_OE_N && !SDO && age_r > 8'h08) ?
				busy_r + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	chk_oe_release: assert property (
		lo_r >= 8'h07 |-> SDO_OE_N) else $error("driven while deselected");
	chk_oe_needs_sel: assert property (
		$fell(SDO_OE_N) |-> SEL && $past(SEL, 2)) else $error("early drive");
	chk_oe_holds: assert property (
		SEL [*6] ##0 !SDO_OE_N |=> !SDO_OE_N) else $error("stream cut");
	chk_oe_off_late: assert property (
		$rose(SDO_OE_N) |-> !$past(SEL, 2)) else $error("released early");
	chk_dummy_zero: assert property (
		$fell(SDO_OE_N) && age_r <= 8'h07 |-> !SDO) else $error("no dummy");
	chk_sdo_on_sck: assert property (
		SEL && !SDO_OE_N && !$past(SDO_OE_N) && $fell(SDO)
		|-> age_r >= 8'h01 && age_r <= 8'h06) else $error("stray change");
	chk_ready_holds: assert property (
		SEL && !SDO_OE_N && SDO && age_r > 8'h08 |=> SDO || SDO_OE_N)
		else $error("ready reverted");
	chk_busy_bound: assert property (
		busy_r <= 32'(PROG_CYC + 8)) else $error("busy too long");
endmodule: sea_eeprom_chk

bind sea_eeprom sea_eeprom_chk #(.PROG_CYC(PROG_CYC)) u_chk (
	.CLK     (CLK),
	.SYS_RST (SYS_RST),
	.SEL     (SEL),
	.SCK     (SCK),
	.SDO     (SDO),
	.SDO_OE_N(SDO_OE_N)
);

`default_nettype wire

// ### testbench/sea_host.sv
`timescale 1ns/10ps
`default_nettype none

// Serial master in place of the host controller
module sea_host (
	input  wire logic clk,
	output logic      sel,
	output logic      sck,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe_n
);
	logic last_r = 1'b0;
	logic sdo_w;

	// Released output floats: show the inverse of its last level
	always @(posedge clk) if (!sdo_oe_n) last_r <= sdo;
	assign sdo_w = sdo_oe_n ? ~last_r : sdo;

	// Clock and data low, chip deselected
	initial begin
		sel = 1'b0;
		sck = 1'b0;
		sdi = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask: tick

	// 80 ns bit; output taken as the clock falls, 40 ns after the rise
	task automatic bit_io(input logic d, output logic q);
		sdi = d;
		tick(4);
		sck = 1'b1;
		tick(4);
		sck = 1'b0;
		q = sdo_w;
	endtask: bit_io

	task automatic shift(input logic [15:0] v, input int n,
		output logic [15:0] q);
		logic b;
		q = 16'h0;
		for (int i = n - 1; i >= 0; i--) begin
			bit_io(v[i], b);
			q = {q[14:0], b};
		end
	endtask: shift

	// Frame opening; fp rides the ignored first pulse, dum is the bit
	// seen after the last address bit
	task automatic cmd(input logic [3:0] op, input logic [4:0] a,
		input int na, input logic fp, output logic dum);
		logic [15:0] q;
		sel = 1'b1;
		tick(4);
		bit_io(fp, dum);
		bit_io(1'b1, dum);
		shift({12'h0, op}, 4, q);
		shift({11'h0, a}, na, q);
		dum = q[0];
	endtask: cmd

	// Gap well above the minimum deselect time
	task automatic stop();
		sel = 1'b0;
		tick(30);
	endtask: stop

	// Status poll; clock may keep running during busy
	task automatic poll(input logic run, output logic busy,
		output logic rdy, output int n);
		sel = 1'b1;
		tick(6);
		busy = !sdo_oe_n && !sdo_w;
		for (n = 0; n < 3000 && (sdo_oe_n || !sdo_w); n++) begin
			if (run && n % 8 == 0) sck = !sck;
			tick(1);
		end
		sck = 1'b0;
		// Select held on so the ready level must be seen to stand
		tick(12);
		rdy = !sdo_oe_n && sdo_w;
		stop();
	endtask: poll
endmodule: sea_host

`default_nettype wire
